//--- pkg/rstcfg_defines.svh
// Offsets, field positions, reset values and timing counts of the reset and strap block.
`ifndef RSTCFG_DEFINES_SVH
`define RSTCFG_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RC_OFF_STATUS    12'h000
`define RC_OFF_GPIO_FN   12'h004
`define RC_OFF_GPIO_OUT  12'h008
`define RC_OFF_GPIO_IN   12'h00C
`define RC_OFF_IRQ_STS   12'h010
`define RC_OFF_IRQ_CLR   12'h014
`define RC_OFF_IRQ_EN    12'h018
`define RC_OFF_DIFF_SEL  12'h01C

// ==========================================================
// Field positions
`define RC_BIT_READY     7
`define RC_BIT_HOST      0
`define RC_BIT_RATE_LO   1
`define RC_BIT_RATE_HI   2
`define RC_BIT_FAULT     3
`define RC_PIN_RATE_LO   0
`define RC_PIN_RATE_HI   1
`define RC_PIN_HOST      3
`define RC_PIN_LOW       4
`define RC_EV_READY      0
`define RC_EV_LOCK       1
`define RC_EV_HOLD       2
`define RC_EV_REFFAIL    3

// ==========================================================
// Reset values
`define RC_PULL_UP_RST   7'h40
`define RC_GPIO_FN_RST   28'h0000000
`define RC_DIFF_SEL_RST  24'hFAC688
`define RC_IRQ_EN_RST    4'h0

// ==========================================================
// Timing
`define RC_CLK_MHZ       125
`define RC_STRAP_MS      125
`define RC_STRAP_CYCLES  (`RC_STRAP_MS * 1000 * `RC_CLK_MHZ)

`endif

//--- pkg/rstcfg_pkg.sv
// Types shared by the reset and strap configuration block.
package rstcfg_pkg;

  typedef enum logic [1:0] {
    RC_ST_RESET,
    RC_ST_STRAP,
    RC_ST_READY
  } rstcfg_state_type;

  typedef enum logic [3:0] {
    RC_FN_IN,
    RC_FN_OUT,
    RC_FN_IRQ,
    RC_FN_LOCK,
    RC_FN_HOLD,
    RC_FN_REFFAIL,
    RC_FN_REFSEL_IN,
    RC_FN_REFSEL_MON,
    RC_FN_DIFF_EN,
    RC_FN_CMOS_EN
  } rstcfg_fn_type;

endpackage

//--- pkg/rstcfg_pin_if.sv
// Carrier between the pin synchroniser and the core.
`timescale 1ns/1ps
`default_nettype none
interface rstcfg_pin_if;
  logic [7:0] raw;
  logic [7:0] level;
  modport sync (input raw, output level);
  modport core (output raw, input level);
endinterface
`default_nettype wire

//--- core/rstcfg_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module rstcfg_pin_sync
  import rstcfg_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  rstcfg_pin_if.sync  pins
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
  } rstcfg_sync_type;

  rstcfg_sync_type q;
  rstcfg_sync_type d;

  // ==========================================================
  // Next state
  // A level only moves when the second and third stage agree, so a
  // metastable first stage never reaches the core.
  always_comb begin
    d     = q;
    d.s1  = pins.raw;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s3 & ~(q.s2 ^ q.s3)) | (q.lvl & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.level = q.lvl;

endmodule
`default_nettype wire

//--- core/rstcfg_top.sv
// Reset sequencing, strap capture, GPIO functions and output clock selection.
//
// Behaviour
// - A low level on the power-on reset pin holds the device in reset.
// - Bit 7 at address 0x000 rises when registers become accessible.
// - Host-mode strap level selects I2C or SPI host interface.
// - A pin can be host interrupt, lock, holdover or reference-fail output.
// - Pins can control or monitor reference select and enable outputs.
// - Each of eight differential outputs selects any available clock.
// - Undriven pins default low for pins 5:0 and high for pin 6.
`timescale 1ns/1ps
`default_nettype none
`include "rstcfg_defines.svh"
module rstcfg_top
  import rstcfg_pkg::*;
#(
  parameter int unsigned STRAP_CYCLES = `RC_STRAP_CYCLES
)(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PWR_RST_N,
  input  wire logic [6:0]  GPIO_I,
  output var  logic [6:0]  GPIO_O,
  output var  logic [6:0]  GPIO_OE,
  output var  logic [6:0]  GPIO_PULL_UP,
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [31:0] REG_RDATA,
  output var  logic        IRQ,
  output var  logic        DEV_READY,
  output var  logic        HOST_MODE_SPI,
  output var  logic [1:0]  CLK_RATE_SEL,
  input  wire logic        DPLL_LOCK,
  input  wire logic        DPLL_HOLDOVER,
  input  wire logic        REF_FAIL,
  input  wire logic        REF_ACTIVE,
  output var  logic        REF_SEL_REQ,
  output var  logic        DIFF_OUT_EN,
  output var  logic        CMOS_OUT_EN,
  output var  logic [23:0] DIFF_SRC_SEL
);

  typedef struct packed {
    rstcfg_state_type st;
    logic [23:0]      cnt;
    logic             ready;
    logic             host_spi;
    logic [1:0]       rate;
    logic             fault;
    logic [27:0]      gpio_fn;
    logic [6:0]       gpio_dout;
    logic [3:0]       irq_sts;
    logic [3:0]       irq_en;
    logic [23:0]      diff_sel;
    logic             lock_p;
    logic             hold_p;
    logic             fail_p;
    logic [31:0]      rdata;
    logic [6:0]       gpio_o;
    logic [6:0]       gpio_oe;
    logic [6:0]       pull_up;
    logic             irq;
    logic             ref_req;
    logic             diff_en;
    logic             cmos_en;
  } rstcfg_core_type;

  rstcfg_core_type q;
  rstcfg_core_type d;

  rstcfg_pin_if pins ();

  logic       pwr_level;
  logic [6:0] gpio_level;
  logic       dev_rst;

  // ==========================================================
  // Pin synchronisers
  assign pins.raw   = {PWR_RST_N, GPIO_I};
  assign pwr_level  = pins.level[7];
  assign gpio_level = pins.level[6:0];

  rstcfg_pin_sync u_sync (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .pins (pins)
  );

  // The reset pin is filtered first, so a glitch shorter than two
  // clocks cannot restart the strap interval.
  assign dev_rst = SYS_RST | ~pwr_level;

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic rstcfg_fn_type pin_fn(input logic [27:0] fns, input int i);
    pin_fn = rstcfg_fn_type'(fns[i*4 +: 4]);
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0]    ev;
    logic [3:0]    clr;
    logic          wr_ok;
    rstcfg_fn_type fn;
    ev    = '0;
    clr   = '0;
    wr_ok = 1'b0;
    fn    = RC_FN_IN;
    d       = q;
    d.rdata = '0;
    d.lock_p = DPLL_LOCK;
    d.hold_p = DPLL_HOLDOVER;
    d.fail_p = REF_FAIL;
    unique case (q.st)
      RC_ST_RESET: begin
        d.st  = RC_ST_STRAP;
        d.cnt = '0;
      end
      RC_ST_STRAP: begin
        d.cnt = q.cnt + 24'h000001;
        if (q.cnt == 24'(STRAP_CYCLES - 1)) begin
          // Straps are sampled at the end of the hold window the board
          // guarantees, and are not sampled again until the next reset.
          d.host_spi = gpio_level[`RC_PIN_HOST];
          d.rate = {gpio_level[`RC_PIN_RATE_HI],
                    gpio_level[`RC_PIN_RATE_LO]};
          d.fault = gpio_level[`RC_PIN_LOW];
          d.ready = 1'b1;
          d.st    = RC_ST_READY;
          ev[`RC_EV_READY] = 1'b1;
        end
      end
      RC_ST_READY: begin
        wr_ok = REG_WR;
      end
      default: begin
        d.st = RC_ST_RESET;
      end
    endcase

    // Status events, edge detected on the same clock.
    if (q.ready) begin
      ev[`RC_EV_LOCK]    = DPLL_LOCK ^ q.lock_p;
      ev[`RC_EV_HOLD]    = DPLL_HOLDOVER ^ q.hold_p;
      ev[`RC_EV_REFFAIL] = REF_FAIL ^ q.fail_p;
    end

    // Writes are accepted only once ready; earlier ones are dropped.
    if (wr_ok) begin
      if (hit(REG_ADDR, `RC_OFF_GPIO_FN)) begin
        d.gpio_fn = REG_WDATA[27:0];
      end
      if (hit(REG_ADDR, `RC_OFF_GPIO_OUT)) begin
        d.gpio_dout = REG_WDATA[6:0];
      end
      if (hit(REG_ADDR, `RC_OFF_IRQ_CLR)) begin
        clr = REG_WDATA[3:0];
      end
      if (hit(REG_ADDR, `RC_OFF_IRQ_EN)) begin
        d.irq_en = REG_WDATA[3:0];
      end
      if (hit(REG_ADDR, `RC_OFF_DIFF_SEL)) begin
        d.diff_sel = REG_WDATA[23:0];
      end
    end

    // A new event in the cycle of its clear survives the clear.
    d.irq_sts = (q.irq_sts & ~clr) | ev;
    d.irq     = |(d.irq_sts & d.irq_en);

    // Reads; the status word is available even before ready so it can
    // be polled.
    if (REG_RD) begin
      if (hit(REG_ADDR, `RC_OFF_STATUS)) begin
        d.rdata[`RC_BIT_READY]   = q.ready;
        d.rdata[`RC_BIT_HOST]    = q.host_spi;
        d.rdata[`RC_BIT_RATE_LO] = q.rate[0];
        d.rdata[`RC_BIT_RATE_HI] = q.rate[1];
        d.rdata[`RC_BIT_FAULT]   = q.fault;
      end else if (q.ready) begin
        if (hit(REG_ADDR, `RC_OFF_GPIO_FN)) begin
          d.rdata[27:0] = q.gpio_fn;
        end
        if (hit(REG_ADDR, `RC_OFF_GPIO_OUT)) begin
          d.rdata[6:0] = q.gpio_dout;
        end
        if (hit(REG_ADDR, `RC_OFF_GPIO_IN)) begin
          d.rdata[6:0] = gpio_level;
        end
        if (hit(REG_ADDR, `RC_OFF_IRQ_STS)) begin
          d.rdata[3:0] = q.irq_sts;
        end
        if (hit(REG_ADDR, `RC_OFF_IRQ_EN)) begin
          d.rdata[3:0] = q.irq_en;
        end
        if (hit(REG_ADDR, `RC_OFF_DIFF_SEL)) begin
          d.rdata[23:0] = q.diff_sel;
        end
      end
    end

    // Pin functions. Until ready every pin floats on its pull so the
    // straps are not disturbed.
    d.gpio_o  = '0;
    d.gpio_oe = '0;
    d.ref_req = 1'b0;
    d.diff_en = 1'b1;
    d.cmos_en = 1'b1;
    if (q.ready) begin
      for (int i = 0; i < 7; i++) begin
        fn = pin_fn(q.gpio_fn, i);
        unique case (fn)
          RC_FN_OUT: begin
            d.gpio_o[i]  = q.gpio_dout[i];
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_IRQ: begin
            d.gpio_o[i]  = d.irq;
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_LOCK: begin
            d.gpio_o[i]  = DPLL_LOCK;
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_HOLD: begin
            d.gpio_o[i]  = DPLL_HOLDOVER;
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_REFFAIL: begin
            d.gpio_o[i]  = REF_FAIL;
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_REFSEL_MON: begin
            d.gpio_o[i]  = REF_ACTIVE;
            d.gpio_oe[i] = 1'b1;
          end
          RC_FN_REFSEL_IN: begin
            d.ref_req = d.ref_req | gpio_level[i];
          end
          RC_FN_DIFF_EN: begin
            d.diff_en = d.diff_en & gpio_level[i];
          end
          RC_FN_CMOS_EN: begin
            d.cmos_en = d.cmos_en & gpio_level[i];
          end
          RC_FN_IN: begin
          end
          default: begin
          end
        endcase
      end
    end
    d.pull_up = `RC_PULL_UP_RST;

    if (dev_rst) begin
      d          = '0;
      d.st       = RC_ST_RESET;
      d.gpio_fn  = `RC_GPIO_FN_RST;
      d.irq_en   = `RC_IRQ_EN_RST;
      d.diff_sel = `RC_DIFF_SEL_RST;
      d.pull_up  = `RC_PULL_UP_RST;
      d.diff_en  = 1'b1;
      d.cmos_en  = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    q <= d;
  end

  // ==========================================================
  // Outputs
  assign GPIO_O        = q.gpio_o;
  assign GPIO_OE       = q.gpio_oe;
  assign GPIO_PULL_UP  = q.pull_up;
  assign REG_RDATA     = q.rdata;
  assign IRQ           = q.irq;
  assign DEV_READY     = q.ready;
  assign HOST_MODE_SPI = q.host_spi;
  assign CLK_RATE_SEL  = q.rate;
  assign REF_SEL_REQ   = q.ref_req;
  assign DIFF_OUT_EN   = q.diff_en;
  assign CMOS_OUT_EN   = q.cmos_en;
  assign DIFF_SRC_SEL  = q.diff_sel;

endmodule
`default_nettype wire

//--- dv/rstcfg_top_asserts.sv
// Port checks of the reset and strap block.
`timescale 1ns/1ps
`default_nettype none
module rstcfg_chk #(
  parameter int unsigned STRAP_CYCLES = 20
)(
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        PWR_RST_N,
  input wire logic [6:0]  GPIO_OE,
  input wire logic [6:0]  GPIO_PULL_UP,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        IRQ,
  input wire logic        DEV_READY,
  input wire logic        HOST_MODE_SPI,
  input wire logic [1:0]  CLK_RATE_SEL,
  input wire logic [23:0] DIFF_SRC_SEL
);
  // ==========================================
  // Cycles since the reset pin went high
  logic [31:0] wait_q;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !PWR_RST_N || DEV_READY) begin
      wait_q <= 32'h0;
    end else begin
      wait_q <= wait_q + 32'h1;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_rd_ready;
    REG_RD && REG_ADDR == 12'h000 && DEV_READY;
  endsequence
  sequence s_wr_diff;
    REG_WR && REG_ADDR == 12'h01C && DEV_READY;
  endsequence
  sequence s_wr_mask;
    REG_WR && REG_ADDR == 12'h018 && REG_WDATA[3:0] == 4'h0 && DEV_READY;
  endsequence
  AST_READY_BIT: assert property (s_rd_ready |=> REG_RDATA[7])
    else $error("ready bit missing in status read");
  AST_READY_EARLY: assert property ($rose(DEV_READY) |-> wait_q >= STRAP_CYCLES)
    else $error("ready rose before the strap interval");
  AST_READY_LATE: assert property (wait_q <= STRAP_CYCLES + 12)
    else $error("ready did not rise in time");
  AST_PWR_RESET: assert property (!PWR_RST_N [*8] |-> !DEV_READY && !IRQ)
    else $error("reset pin low but block not in reset");
  AST_STRAP_HOLD: assert property (DEV_READY && $past(DEV_READY) |->
    $stable(HOST_MODE_SPI) && $stable(CLK_RATE_SEL))
    else $error("strap selection changed while ready");
  AST_OE_IDLE: assert property (!DEV_READY |-> GPIO_OE == 7'h00)
    else $error("pin driven before ready");
  AST_PULLS: assert property (GPIO_PULL_UP == 7'h40)
    else $error("pull directions wrong");
  AST_IRQ_MASK: assert property (s_wr_mask |=> !IRQ)
    else $error("interrupt high with all enables off");
  AST_DIFF_SEL: assert property (s_wr_diff |=> ##1
    DIFF_SRC_SEL == $past(REG_WDATA[23:0], 2))
    else $error("output source select not taken");
endmodule
bind rstcfg_top rstcfg_chk #(.STRAP_CYCLES(STRAP_CYCLES)) chk_u (.SYS_CLK, .SYS_RST,
  .PWR_RST_N, .GPIO_OE, .GPIO_PULL_UP, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
  .IRQ, .DEV_READY, .HOST_MODE_SPI, .CLK_RATE_SEL, .DIFF_SRC_SEL);
`default_nettype wire

//--- dv/rstcfg_board.sv
// Board reset supervisor and strap resistors facing the block.
`timescale 1ns/1ps
`default_nettype none
module rstcfg_board #(
  parameter int unsigned STRAP_CYCLES = 20
)(
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] straps,
  input  wire logic [3:0] extra,
  output var  logic       pwr_rst_n,
  output var  logic [6:0] pins,
  output var  logic       busy
);
  // ==========================================
  // Sequence
  int unsigned cnt_q;
  initial begin
    pwr_rst_n = 1'b1;
    pins      = 7'h40;
    busy      = 1'b0;
    cnt_q     = 0;
  end
  // The long supply hold is cut to a few cycles; the block does not time it.
  always @(posedge clk) begin
    if (start) begin
      busy      <= 1'b1;
      cnt_q     <= 0;
      pwr_rst_n <= 1'b0;
      pins      <= {2'b10, straps[3:2], 1'b0, straps[1:0]};
    end else if (busy) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == 10 + extra) pwr_rst_n <= 1'b1;
      if (cnt_q == 22 + extra + STRAP_CYCLES) begin
        pins <= 7'h40;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/rstcfg_top_tb.sv
// Self-checking bench of the reset and strap block.
`timescale 1ns/1ps
`default_nettype none
module rstcfg_top_tb;
  // ==========================================
  // Signals
  localparam int unsigned SC = 20;
  logic        SYS_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        PWR_RST_N;
  logic [6:0]  GPIO_I, GPIO_O, GPIO_OE, GPIO_PULL_UP, pins;
  logic [11:0] REG_ADDR = 12'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic        IRQ, DEV_READY, HOST_MODE_SPI, REF_SEL_REQ, DIFF_OUT_EN, CMOS_OUT_EN;
  logic [1:0]  CLK_RATE_SEL;
  logic        DPLL_LOCK, DPLL_HOLDOVER, REF_FAIL, busy;
  logic        REF_ACTIVE = 1'b0;
  logic        start = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  straps = 4'h0;
  logic [3:0]  extra = 4'h0;
  logic [23:0] DIFF_SRC_SEL;
  int          err_count = 0;
  int          n_compared = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  assign {REF_FAIL, DPLL_HOLDOVER, DPLL_LOCK} = ev;
  assign GPIO_I = (GPIO_OE & GPIO_O) | (~GPIO_OE & pins);
  rstcfg_board #(.STRAP_CYCLES(SC)) board_u (.clk(SYS_CLK), .start(start), .straps(straps),
    .extra(extra), .pwr_rst_n(PWR_RST_N), .pins(pins), .busy(busy));
  rstcfg_top #(.STRAP_CYCLES(SC)) dut_u (.SYS_CLK, .SYS_RST, .PWR_RST_N, .GPIO_I, .GPIO_O,
    .GPIO_OE, .GPIO_PULL_UP, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ,
    .DEV_READY, .HOST_MODE_SPI, .CLK_RATE_SEL, .DPLL_LOCK, .DPLL_HOLDOVER, .REF_FAIL,
    .REF_ACTIVE, .REF_SEL_REQ, .DIFF_OUT_EN, .CMOS_OUT_EN, .DIFF_SRC_SEL);
  // ==========================================
  // Tasks
  function automatic logic [31:0] exp_status(input logic [3:0] s);
    return {24'h0, 4'h8, s[3], s[1:0], s[2]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [23:0] got, input logic [23:0] exp);
    chk({8'h0, got}, {8'h0, exp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic boot(input logic [3:0] s);
    logic [31:0] st;
    int          i;
    st = 32'h0;
    @(posedge SYS_CLK);
    straps <= s;
    extra  <= 4'($urandom_range(5, 0));
    start  <= 1'b1;
    @(posedge SYS_CLK);
    start <= 1'b0;
    for (i = 0; i < 40 && DEV_READY !== 1'b0; i++) @(posedge SYS_CLK);
    #1;
    chk_pin(24'(DEV_READY), 24'h0);
    // A write in the strap interval must be dropped; the check after the last boot covers it.
    for (i = 0; i < 40 && PWR_RST_N !== 1'b1; i++) @(posedge SYS_CLK);
    repeat (8) @(posedge SYS_CLK);
    wr(12'h01C, 32'h00FFFFFF);
    for (i = 0; i < SC + 40 && st[7] !== 1'b1; i++) rd(12'h000, st);
    chk(st, exp_status(s));
    chk_pin(24'({HOST_MODE_SPI, CLK_RATE_SEL}), 24'(s[2:0]));
    for (i = 0; i < SC + 40 && busy; i++) @(posedge SYS_CLK);
    settle();
    chk_pin(24'({HOST_MODE_SPI, CLK_RATE_SEL}), 24'(s[2:0]));
    rdc(12'h000, exp_status(s));
  endtask
  task automatic finish_test();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_count++;
    finish_test();
  end
  initial begin
    logic [31:0] d;
    int          k;
    d = $urandom(84175);
    repeat (16) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    boot(4'h7);
    boot(4'h8);
    for (k = 0; k < 3; k++) boot({1'b0, 3'($urandom)});
    chk_pin(DIFF_SRC_SEL, 24'hFAC688);
    d = $urandom;
    wr(12'h01C, {8'h0, d[23:0]});
    rdc(12'h01C, {8'h0, d[23:0]});
    chk_pin(DIFF_SRC_SEL, d[23:0]);
    rdc(12'h0FC, 32'h0);
    wr(12'h018, 32'h1);
    settle();
    chk_pin(24'(IRQ), 24'h1);
    wr(12'h018, 32'h0);
    wr(12'h014, 32'hF);
    rdc(12'h010, 32'h0);
    for (k = 0; k < 3; k++) begin
      wr(12'h018, 32'h2 << k);
      ev <= ev ^ (3'h1 << k);
      settle();
      chk_pin(24'(IRQ), 24'h1);
      rdc(12'h010, 32'h2 << k);
      wr(12'h014, 32'hF);
      settle();
      chk_pin(24'(IRQ), 24'h0);
    end
    wr(12'h004, 32'h09870316);
    REF_ACTIVE <= 1'b1;
    wr(12'h008, 32'h2);
    settle();
    chk_pin(24'({GPIO_OE, GPIO_O & GPIO_OE}), 24'h000B16);
    chk_pin(24'({REF_SEL_REQ, DIFF_OUT_EN, CMOS_OUT_EN}), 24'h1);
    rdc(12'h00C, 32'h56);
    // Status pin functions and input functions that can read back high.
    wr(12'h004, 32'h06005429);
    wr(12'h018, 32'h2);
    ev <= 3'h6;
    settle();
    chk_pin(24'({GPIO_OE, GPIO_O & GPIO_OE}), 24'h00070E);
    chk_pin(24'({REF_SEL_REQ, DIFF_OUT_EN, CMOS_OUT_EN}), 24'h6);
    rdc(12'h00C, 32'h4E);
    rdc(12'h004, 32'h06005429);
    rdc(12'h018, 32'h2);
    rdc(12'h014, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
